// file: async_static_ram_2kx8_port_test.sv
// Purpose: Self-checking bench for the memory host controller
// Assumes: Memory model on the pins, seed 4
// Notes:   Reads only hit words written earlier
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module async_static_ram_2kx8_port_test;
	logic MCLK = 0, RST_N = 0, REQ_VALID = 0, REQ_WRITE = 0, REQ_READY, RSP_VALID;
	logic SEL_N, WSTB_N, ODRV_N, DATA_PINS_OE;
	logic [10:0] REQ_ADDR = 11'h000, ADDR_PINS;
	logic [7:0] REQ_WDATA = 8'h00, RSP_RDATA, DATA_PINS_IN, DATA_PINS_OUT;
	logic [7:0] ref_mem [2048];
	logic [10:0] a;
	int n_mismatch = 0, compares = 0, cyc = 0;
	sram_host_ctrl DUT (.MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
		.REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
		.REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
		.ADDR_PINS(ADDR_PINS), .SEL_N(SEL_N), .WSTB_N(WSTB_N), .ODRV_N(ODRV_N),
		.DATA_PINS_IN(DATA_PINS_IN), .DATA_PINS_OUT(DATA_PINS_OUT),
		.DATA_PINS_OE(DATA_PINS_OE));
	sram_dev_model u_mem (.clk(MCLK), .addr_pins(ADDR_PINS), .sel_n(SEL_N),
		.wstb_n(WSTB_N), .odrv_n(ODRV_N), .host_out(DATA_PINS_OUT),
		.host_oe(DATA_PINS_OE), .data_pins(DATA_PINS_IN));
	initial begin
		forever #2.5 MCLK = ~MCLK;
	end
	// Cut a hang well past the few thousand cycles the tests need
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	function automatic logic [7:0] expect_rd(input logic [10:0] ad);
		return ref_mem[ad];
	endfunction : expect_rd
	task automatic access(input logic wr, input logic [10:0] ad, input logic [7:0] d);
		REQ_VALID = 1;
		REQ_WRITE = wr;
		REQ_ADDR = ad;
		REQ_WDATA = d;
		while (REQ_READY !== 1'b1) begin
			@(posedge MCLK); #1;
		end
		@(posedge MCLK); #1;
		REQ_VALID = 0;
		while (RSP_VALID !== 1'b1) begin
			@(posedge MCLK); #1;
		end
		if (wr) ref_mem[ad] = d;
		else `CHK(RSP_RDATA, expect_rd(ad))
	endtask : access
	task automatic check_idle();
		`CHK({SEL_N, WSTB_N, ODRV_N, DATA_PINS_OE, REQ_READY, RSP_VALID}, 6'h3A)
	endtask : check_idle
	task automatic final_report();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	initial begin
		void'($urandom(4));
		repeat (12) @(posedge MCLK);
		#1;
		`CHK({SEL_N, WSTB_N, ODRV_N, DATA_PINS_OE, REQ_READY, RSP_VALID}, 6'h38)
		RST_N = 1;
		@(posedge MCLK); #1;
		check_idle();
		// Array edges and all-zero/all-one data, then write-read on the same word
		access(1, 11'h000, 8'hFF);
		access(1, 11'h7FF, 8'h00);
		access(0, 11'h000, 8'h00);
		access(0, 11'h7FF, 8'h00);
		for (int i = 0; i < 60; i++) begin
			a = 11'($urandom);
			access(1, a, 8'($urandom));
			access(0, a, 8'h00);
		end
		// Reset between accesses: the controller comes back idle and the
		// stored words survive, since the memory itself has no reset
		RST_N = 0;
		repeat (3) @(posedge MCLK);
		#1 RST_N = 1;
		@(posedge MCLK); #1;
		check_idle();
		access(0, 11'h7FF, 8'h00);
		access(0, a, 8'h00);
		final_report();
	end
endmodule : async_static_ram_2kx8_port_test
`default_nettype wire

// file: sram_dev_model.sv
// Purpose: Behavioural 2K x 8 asynchronous static memory on the far side
// Assumes: Host splits the data pins into value and enable
// Notes:   Released pins show the inverse of their last level
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model (
	input  wire logic        clk,
	input  wire logic [10:0] addr_pins,
	input  wire logic        sel_n,
	input  wire logic        wstb_n,
	input  wire logic        odrv_n,
	input  wire logic [7:0]  host_out,
	input  wire logic        host_oe,
	output logic      [7:0]  data_pins
);
	logic [7:0] mem [2048];
	logic [7:0] last = 8'h00;
	logic       drive;
	logic       standby;
	logic       valid;
	int         held = 0;
	assign standby = sel_n;
	// Strobe low blocks driving, so simultaneous falls stay undriven
	assign drive = !standby && !odrv_n && wstb_n;
	// Output is only valid once select and output drive have been low for
	// RD_CYCLES - 1 cycles, one short of the access time; a host that samples early sees junk
	assign valid = held >= int'(sram_host_pkg::RD_CYCLES) - 1;
	assign data_pins = host_oe ? host_out : (drive && valid) ? mem[addr_pins] : ~last;
	always @* begin
		if (!sel_n && !wstb_n) begin
			mem[addr_pins] = data_pins;
		end
	end
	always @(posedge clk) begin
		last <= data_pins;
		if (!drive)
			held <= 0;
		else if (held < 255)
			held <= held + 1;
	end
endmodule : sram_dev_model
`default_nettype wire

// file: sram_host_ctrl.sv
// Purpose: Host-side controller driving a 2K x 8 asynchronous static memory
// Assumes: Single clock MCLK, synchronous active-low reset, inputs synchronous
// Notes:   One access at a time; data pins are split into in, out and enable
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl (
	input  wire logic                              MCLK,
	input  wire logic                              RST_N,
	input  wire logic                              REQ_VALID,
	input  wire logic                              REQ_WRITE,
	input  wire logic [sram_host_pkg::ADDR_W-1:0]  REQ_ADDR,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  REQ_WDATA,
	output logic                                   REQ_READY,
	output logic                                   RSP_VALID,
	output logic [sram_host_pkg::DATA_W-1:0]       RSP_RDATA,
	output logic [sram_host_pkg::ADDR_W-1:0]       ADDR_PINS,
	output logic                                   SEL_N,
	output logic                                   WSTB_N,
	output logic                                   ODRV_N,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  DATA_PINS_IN,
	output logic [sram_host_pkg::DATA_W-1:0]       DATA_PINS_OUT,
	output logic                                   DATA_PINS_OE
);
	sram_host_pkg::state_t state;
	sram_host_pkg::state_t next_state;

	logic                              pend_write;
	logic                              timer_load;
	logic [sram_host_pkg::CNT_W-1:0]   timer_value;
	logic                              timer_done;
	wire                               take_req;
	wire                               in_idle;

	// Decoded phase flags
	wire                               next_idle;
	wire                               next_read;
	wire                               next_write;
	wire                               next_hold;
	wire                               rd_done;
	wire                               wr_done;
	wire                               host_drive;

	// ------------------------------------------------------------------
	// Phase timer
	// ------------------------------------------------------------------
	// One shared timer: phases never overlap, so a second counter would idle
	sram_host_timer u_timer (
		.clk   (MCLK),
		.rst_n (RST_N),
		.load  (timer_load),
		.value (timer_value),
		.done  (timer_done)
	);

	assign in_idle  = (state == sram_host_pkg::ST_IDLE);
	assign take_req = in_idle && REQ_VALID;

	// ------------------------------------------------------------------
	// Decoding of the coming phase
	// ------------------------------------------------------------------
	// Pins are registered from the next state, so each pin changes on the
	// same edge as the phase it belongs to and never lags by a cycle.
	assign next_idle  = (next_state == sram_host_pkg::ST_IDLE);
	assign next_read  = (next_state == sram_host_pkg::ST_READ);
	assign next_write = (next_state == sram_host_pkg::ST_WRITE);
	assign next_hold  = (next_state == sram_host_pkg::ST_HOLD);
	// Read data is taken on the last edge of the select window, before
	// select rises; a write answers from its hold cycle.
	assign rd_done    = (state == sram_host_pkg::ST_READ) && timer_done;
	assign wr_done    = (state == sram_host_pkg::ST_HOLD) && pend_write;
	// Host drives data through the strobe and one cycle beyond it, so
	// data is still held when the strobe edge that ends the write passes.
	assign host_drive = next_write || next_hold;

	// ------------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------------
	// A write first waits out the device output turn-off so the host never
	// fights a driven bus; the strobe then falls with select low already.
	// Counts come from the slowest grade, rounded up to whole cycles:
	// a read keeps select and output drive low for the full access time,
	// a write waits out the turn-off, holds the strobe for the full pulse
	// width and then keeps data on the pins for one more cycle.
	// Limitation: one access at a time; faster grades gain nothing.
	// The write always ends on the strobe, never on select.
	always_comb begin
		next_state  = state;
		timer_load  = 1'b0;
		timer_value = sram_host_pkg::CNT_ZERO;
		unique case (state)
			sram_host_pkg::ST_IDLE: begin
				if (REQ_VALID) begin
					timer_load = 1'b1;
					if (REQ_WRITE) begin
						next_state  = sram_host_pkg::ST_TURN;
						timer_value = sram_host_pkg::TURN_CYCLES;
					end else begin
						next_state  = sram_host_pkg::ST_READ;
						timer_value = sram_host_pkg::RD_CYCLES;
					end
				end
			end
			sram_host_pkg::ST_TURN: begin
				if (timer_done) begin
					next_state  = sram_host_pkg::ST_WRITE;
					timer_load  = 1'b1;
					timer_value = sram_host_pkg::WR_CYCLES;
				end
			end
			sram_host_pkg::ST_READ: begin
				if (timer_done)
					next_state = sram_host_pkg::ST_IDLE;
			end
			sram_host_pkg::ST_WRITE: begin
				if (timer_done)
					next_state = sram_host_pkg::ST_HOLD;
			end
			sram_host_pkg::ST_HOLD: begin
				next_state = sram_host_pkg::ST_IDLE;
			end
		endcase
	end

	// Reset parks the sequencer in idle with every control inactive
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			state <= sram_host_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------------
	// Request capture; address held for the whole access
	// ------------------------------------------------------------------
	// Write data is latched with the address, long before the strobe falls
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			ADDR_PINS     <= '0;
			DATA_PINS_OUT <= '0;
			pend_write    <= 1'b0;
		end else if (take_req) begin
			ADDR_PINS     <= REQ_ADDR;
			DATA_PINS_OUT <= REQ_WDATA;
			pend_write    <= REQ_WRITE;
		end
	end

	// ------------------------------------------------------------------
	// Pin controls
	// ------------------------------------------------------------------
	// Deselect when idle so the device rests in standby between accesses
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			SEL_N <= 1'b1;
		else
			SEL_N <= next_idle;
	end

	// Strobe low only inside a write with a stable address; raising it
	// ends the write while select is still low.
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			WSTB_N <= 1'b1;
		else
			WSTB_N <= !next_write;
	end

	// Output drive only for reads; held high in writes so the device
	// never turns its outputs on against the host.
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			ODRV_N <= 1'b1;
		else
			ODRV_N <= !next_read;
	end

	// Drive data only once the device has released the bus, and keep it
	// through the hold cycle after the strobe rises.
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			DATA_PINS_OE <= 1'b0;
		else
			DATA_PINS_OE <= host_drive;
	end

	// ------------------------------------------------------------------
	// Answers
	// ------------------------------------------------------------------
	// Ready stays low on the taking edge so a held request is not seen twice
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			REQ_READY <= 1'b0;
		else
			REQ_READY <= next_idle && !take_req;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N)
			RSP_VALID <= 1'b0;
		else
			RSP_VALID <= rd_done || wr_done;
	end

	// Read data holds until the next read completes
	always_ff @(posedge MCLK) begin
		if (!RST_N)
			RSP_RDATA <= '0;
		else if (rd_done)
			RSP_RDATA <= DATA_PINS_IN;
	end
endmodule : sram_host_ctrl
`default_nettype wire

// file: sram_host_ctrl_sva.sv
// Purpose: Pin timing checks for the memory host controller
// Assumes: Sees the controller ports only
// Notes:   Cycle counts follow the controller walk
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_sva (
	input wire logic        MCLK,
	input wire logic        RST_N,
	input wire logic        REQ_VALID,
	input wire logic        REQ_WRITE,
	input wire logic        REQ_READY,
	input wire logic        RSP_VALID,
	input wire logic [10:0] ADDR_PINS,
	input wire logic        SEL_N,
	input wire logic        WSTB_N,
	input wire logic        ODRV_N,
	input wire logic [7:0]  DATA_PINS_OUT,
	input wire logic        DATA_PINS_OE
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	property p_addr; $changed(ADDR_PINS) |-> WSTB_N && $past(WSTB_N); endproperty
	a_addr: assert property (p_addr) else $error("address moved in write");
	property p_pulse;
		$fell(WSTB_N) |-> !SEL_N && !$past(SEL_N, 4) ##13 $rose(WSTB_N);
	endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse length");
	property p_end; $rose(WSTB_N) |-> !SEL_N ##1 SEL_N && RSP_VALID; endproperty
	a_end: assert property (p_end) else $error("write end order");
	property p_hold; $rose(WSTB_N) |-> DATA_PINS_OE && $stable(DATA_PINS_OUT); endproperty
	a_hold: assert property (p_hold) else $error("write data not held");
	property p_clash; DATA_PINS_OE |-> ODRV_N && !SEL_N; endproperty
	a_clash: assert property (p_clash) else $error("bus contention");
	property p_rd; REQ_VALID && REQ_READY && !REQ_WRITE |=> !SEL_N && !ODRV_N
		##13 !SEL_N ##1 SEL_N && RSP_VALID; endproperty
	a_rd: assert property (p_rd) else $error("read cycle shape");
	property p_wr;
		REQ_VALID && REQ_READY && REQ_WRITE |=> !SEL_N && ODRV_N ##18 RSP_VALID;
	endproperty
	a_wr: assert property (p_wr) else $error("write cycle shape");
	property p_idle; SEL_N |-> WSTB_N && ODRV_N && !DATA_PINS_OE; endproperty
	a_idle: assert property (p_idle) else $error("controls while deselected");
endmodule : sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva u_chk (.MCLK(MCLK), .RST_N(RST_N),
	.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_READY(REQ_READY),
	.RSP_VALID(RSP_VALID), .ADDR_PINS(ADDR_PINS), .SEL_N(SEL_N), .WSTB_N(WSTB_N),
	.ODRV_N(ODRV_N), .DATA_PINS_OUT(DATA_PINS_OUT), .DATA_PINS_OE(DATA_PINS_OE));
`default_nettype wire

// file: sram_host_pkg.sv
// Purpose: Constants for the host controller of a 2K x 8 asynchronous static memory
// Assumes: 200 MHz controller clock, timing figures of the slowest speed grade
// Notes:   Times are in ns; cycle counts are derived from them
`default_nettype none
package sram_host_pkg;

	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int WORDS  = 2048;

	localparam int CLK_PERIOD_NS = 5;

	// ------------------------------------------------------------------
	// Timing figures in ns
	// ------------------------------------------------------------------
	localparam int T_READ_CYCLE_NS  = 70;	// address-to-data access
	localparam int T_WRITE_PULSE_NS = 65;	// write strobe and select overlap
	localparam int T_DATA_SETUP_NS  = 30;	// data before end of write
	localparam int T_TURN_NS        = 20;	// device output to high impedance

	function automatic int cycles_up(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : cycles_up

	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] RD_CYCLES   = CNT_W'(cycles_up(T_READ_CYCLE_NS));
	localparam logic [CNT_W-1:0] WR_CYCLES   = CNT_W'(cycles_up(T_WRITE_PULSE_NS));
	localparam logic [CNT_W-1:0] TURN_CYCLES = CNT_W'(cycles_up(T_TURN_NS));
	localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TURN,
		ST_READ,
		ST_WRITE,
		ST_HOLD
	} state_t;

endpackage : sram_host_pkg
`default_nettype wire

// file: sram_host_timer.sv
// Purpose: Down counter that times the phases of a memory access
// Assumes: One load per phase; done pulses when the count reaches one
// Notes:   Loads win over counting
`timescale 1ns/1ps
`default_nettype none
module sram_host_timer (
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire logic                              load,
	input  wire logic [sram_host_pkg::CNT_W-1:0]   value,
	output var  logic                              done
);
	logic [sram_host_pkg::CNT_W-1:0] count;

	assign done = (count == sram_host_pkg::CNT_ONE);

	always_ff @(posedge clk) begin
		if (!rst_n)
			count <= sram_host_pkg::CNT_ZERO;
		else if (load)
			count <= value;
		else if (count != sram_host_pkg::CNT_ZERO)
			count <= count - sram_host_pkg::CNT_ONE;
	end
endmodule : sram_host_timer
`default_nettype wire
